// *** rtl/pcr_pkg.sv ***
// constants for the pad control register bank
package pcr_pkg;
    localparam int PCR_NUM_PADS = 45;
    localparam int PCR_ADDR_W = 8;
    localparam logic [7:0] PCR_WORD_BYTES = 8'h04;
    localparam logic [7:0] PCR_BASE_OFFSET = 8'h00;
    // field positions
    localparam int PCR_FUNC_LSB = 0;
    localparam int PCR_SRC_LSB = 3;
    localparam int PCR_OEN_BIT = 5;
    localparam int PCR_PULL_LSB = 6;
    localparam int PCR_DRV_LSB = 8;
    localparam int PCR_SLEW_BIT = 10;
    localparam int PCR_REN_BIT = 11;
    localparam int PCR_SMT_BIT = 12;
    // implemented bits; bit 2 and 31:13 are absent
    localparam logic [31:0] PCR_WR_MASK = 32'h0000_1FFB;
    // value after reset: oen=1, pull=1, drive=1
    localparam logic [31:0] PCR_RESET_WORD = 32'h0000_0160;
    // control source codes
    localparam logic [1:0] PCR_SRC_OWN = 2'h0;
    localparam logic [1:0] PCR_SRC_OTHER = 2'h1;
    localparam logic [1:0] PCR_SRC_FABRIC = 2'h2;
endpackage

// *** rtl/pcr_pad_sel.sv ***
// one pad: output source selection from its control word
module pcr_pad_sel
    import pcr_pkg::*;
(
    input wire logic [31:0] ctrl_word,    // control word of this pad
    input wire logic [3:0] func_out,      // functional outputs, one per code
    input wire logic other_out,           // output from other peripheral
    input wire logic other_oe_n,          // its output enable, low active
    input wire logic fabric_out,          // output from fabric
    input wire logic fabric_oe_n,         // fabric output enable, low active
    output logic pad_out,                 // selected output value
    output logic pad_oe_n                 // selected output enable, low active
);
    logic [1:0] fsel;
    logic [1:0] src;
    assign fsel = ctrl_word[PCR_FUNC_LSB +: 2];
    assign src = ctrl_word[PCR_SRC_LSB +: 2];
    always_comb begin
        unique case (src)
            PCR_SRC_OTHER: begin
                pad_out = other_out;
                pad_oe_n = other_oe_n;
            end
            PCR_SRC_FABRIC: begin
                pad_out = fabric_out;
                pad_oe_n = fabric_oe_n;
            end
            // own fields; code 3 undefined, treated like own
            default: begin
                pad_out = func_out[fsel];
                pad_oe_n = ctrl_word[PCR_OEN_BIT];
            end
        endcase
    end
endmodule

// *** rtl/pcr_bank.sv ***
// pad control register bank with per-pad output routing
// What this block does
// - one 32-bit read/write control word for each of 45 pads
// - bits 1:0 pick the functional output to the pad, reset 0
// - bits 4:3 control source: 0 own, 1 peripheral, 2 fabric
// - bit 5 active-low output enable, reset 1 disables driver
// - bits 7:6 pad state: Z, pull-up, pull-down, keeper; reset 1
// - bits 9:8 drive 2/4/8/12 mA, reset code 1
// - bit 10 slew: 1 fast, 0 slow, reset 0
// - bit 11 receiver enable, bit 12 schmitt enable, reset 0
module pcr_bank
    import pcr_pkg::*;
#(
    parameter int NUM_PADS = PCR_NUM_PADS
)(
    input wire logic clk,                      // 50 MHz system clock
    input wire logic rst_n,                    // async reset, low active
    input wire logic [PCR_ADDR_W-1:0] addr,    // byte address
    input wire logic [31:0] wdata,             // write data
    input wire logic wr,                       // write strobe
    input wire logic rd,                       // read strobe
    input wire logic [4*NUM_PADS-1:0] func_out, // four functions per pad
    input wire logic [NUM_PADS-1:0] other_out, // peripheral outputs
    input wire logic [NUM_PADS-1:0] other_oe_n, // peripheral enables
    input wire logic [NUM_PADS-1:0] fabric_out, // fabric outputs
    input wire logic [NUM_PADS-1:0] fabric_oe_n, // fabric enables
    output logic [31:0] rdata,                 // read data, cycle after rd
    output logic [NUM_PADS-1:0] pad_out,       // pad output value
    output logic [NUM_PADS-1:0] output_enable_n, // pad driver enable, low
    output logic [2*NUM_PADS-1:0] pad_pull,    // pad state code per pad
    output logic [2*NUM_PADS-1:0] pad_drive,   // drive code per pad
    output logic [NUM_PADS-1:0] slew_fast,     // fast slew per pad
    output logic [NUM_PADS-1:0] rx_enable,     // input receiver enable
    output logic [NUM_PADS-1:0] schmitt_input_enable // schmitt per pad
);
    // ========================================================
    // state
    typedef struct packed {
        logic [NUM_PADS-1:0][31:0] word;
        logic [31:0] rdata;
        logic [NUM_PADS-1:0] pad_out;
        logic [NUM_PADS-1:0] oe_n;
        logic [2*NUM_PADS-1:0] pull;
        logic [2*NUM_PADS-1:0] drive;
        logic [NUM_PADS-1:0] slew;
        logic [NUM_PADS-1:0] ren;
        logic [NUM_PADS-1:0] smt;
    } pcr_state_t;

    pcr_state_t st_r;
    pcr_state_t st_nxt;
    logic rst_s1_r;
    logic rst_s2_r;
    logic [NUM_PADS-1:0] sel_out;
    logic [NUM_PADS-1:0] sel_oe_n;

    // ========================================================
    // reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // ========================================================
    // per-pad routing
    genvar g;
    generate
        for (g = 0; g < NUM_PADS; g++) begin : g_pad
            pcr_pad_sel u_sel (
                .ctrl_word(st_r.word[g]),
                .func_out(func_out[4*g +: 4]),
                .other_out(other_out[g]),
                .other_oe_n(other_oe_n[g]),
                .fabric_out(fabric_out[g]),
                .fabric_oe_n(fabric_oe_n[g]),
                .pad_out(sel_out[g]),
                .pad_oe_n(sel_oe_n[g])
            );
            // checks run on every pad; the first cycle after reset is
            // skipped because the outputs still hold their reset values
            a_oen_own: assert property (@(posedge clk)
                disable iff (!rst_s2_r)
                rst_s2_r && st_r.word[g][4:3] == PCR_SRC_OWN |=>
                    output_enable_n[g] == $past(st_r.word[g][PCR_OEN_BIT]))
                else $error("own oe_n wrong");
            a_func_route: assert property (@(posedge clk)
                disable iff (!rst_s2_r)
                rst_s2_r && st_r.word[g][4:3] == PCR_SRC_OWN |=> pad_out[g]
                    == $past(func_out[4*g + 32'(st_r.word[g][1:0])]))
                else $error("function route wrong");
            a_src_fabric: assert property (@(posedge clk)
                disable iff (!rst_s2_r)
                rst_s2_r && st_r.word[g][4:3] == PCR_SRC_FABRIC |=>
                    pad_out[g] == $past(fabric_out[g]) &&
                    output_enable_n[g] == $past(fabric_oe_n[g]))
                else $error("fabric route wrong");
            a_src_other: assert property (@(posedge clk)
                disable iff (!rst_s2_r)
                rst_s2_r && st_r.word[g][4:3] == PCR_SRC_OTHER |=>
                    pad_out[g] == $past(other_out[g]) &&
                    output_enable_n[g] == $past(other_oe_n[g]))
                else $error("peripheral route wrong");
            // code 3 is undefined; it falls back to the word's own fields
            a_src_spare: assert property (@(posedge clk)
                disable iff (!rst_s2_r)
                rst_s2_r && st_r.word[g][4:3] == 2'h3 |=>
                    pad_out[g]
                    == $past(func_out[4*g + 32'(st_r.word[g][1:0])]) &&
                    output_enable_n[g] == $past(st_r.word[g][PCR_OEN_BIT]))
                else $error("spare source code wrong");
            a_pull_map: assert property (@(posedge clk)
                disable iff (!rst_s2_r)
                ##1 pad_pull[2*g +: 2] == $past(st_r.word[g][7:6]))
                else $error("pull code wrong");
            a_drive_map: assert property (@(posedge clk)
                disable iff (!rst_s2_r)
                ##1 pad_drive[2*g +: 2] == $past(st_r.word[g][9:8]))
                else $error("drive code wrong");
            a_slew_rx: assert property (@(posedge clk)
                disable iff (!rst_s2_r)
                ##1 slew_fast[g] == $past(st_r.word[g][10]) &&
                    rx_enable[g] == $past(st_r.word[g][11]) &&
                    schmitt_input_enable[g] == $past(st_r.word[g][12]))
                else $error("slew or input enable wrong");
        end
    endgenerate

    // ========================================================
    // next state
    always_comb begin
        logic [7:0] idx;
        idx = 8'h00;
        st_nxt = st_r;
        st_nxt.rdata = 32'h0000_0000;
        // four-byte stride; the low address bits must be zero to hit a word
        idx = (addr - PCR_BASE_OFFSET) >> 2;
        if (wr && addr[1:0] == 2'h0 && idx < 8'(NUM_PADS)) begin
            st_nxt.word[idx] = wdata & PCR_WR_MASK;
        end
        // unmapped or unaligned reads return zero
        if (rd && addr[1:0] == 2'h0 && idx < 8'(NUM_PADS)) begin
            st_nxt.rdata = st_r.word[idx] & PCR_WR_MASK;
        end
        for (int p = 0; p < NUM_PADS; p++) begin
            st_nxt.pad_out[p] = sel_out[p];
            st_nxt.oe_n[p] = sel_oe_n[p];
            st_nxt.pull[2*p +: 2] = st_r.word[p][PCR_PULL_LSB +: 2];
            st_nxt.drive[2*p +: 2] = st_r.word[p][PCR_DRV_LSB +: 2];
            st_nxt.slew[p] = st_r.word[p][PCR_SLEW_BIT];
            st_nxt.ren[p] = st_r.word[p][PCR_REN_BIT];
            st_nxt.smt[p] = st_r.word[p][PCR_SMT_BIT];
        end
    end

    // ========================================================
    // registers; the pad outputs lag the word by one cycle
    always_ff @(posedge clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            for (int p = 0; p < NUM_PADS; p++) begin
                st_r.word[p] <= PCR_RESET_WORD;
            end
            st_r.rdata <= 32'h0000_0000;
            st_r.pad_out <= '0;
            st_r.oe_n <= '1;
            st_r.pull <= {NUM_PADS{2'h1}};
            st_r.drive <= {NUM_PADS{2'h1}};
            st_r.slew <= '0;
            st_r.ren <= '0;
            st_r.smt <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign pad_out = st_r.pad_out;
    assign output_enable_n = st_r.oe_n;
    assign pad_pull = st_r.pull;
    assign pad_drive = st_r.drive;
    assign slew_fast = st_r.slew;
    assign rx_enable = st_r.ren;
    assign schmitt_input_enable = st_r.smt;

    // ========================================================
    // bus checks
    a_read_data: assert property (@(posedge clk)
        disable iff (!rst_s2_r)
        rd && addr == 8'h00 |=> rdata == ($past(st_r.word[0]) & PCR_WR_MASK))
        else $error("read data mismatch");
    a_write_store: assert property (@(posedge clk)
        disable iff (!rst_s2_r)
        wr && addr == 8'h04 |=> st_r.word[1] == ($past(wdata) & PCR_WR_MASK))
        else $error("write not stored");
    a_reserved_zero: assert property (@(posedge clk)
        disable iff (!rst_s2_r)
        (rdata & ~PCR_WR_MASK) == 32'h0000_0000)
        else $error("reserved bits nonzero");
    a_word_hold: assert property (@(posedge clk)
        disable iff (!rst_s2_r)
        !wr |=> st_r.word == $past(st_r.word))
        else $error("word changed without a write");
    a_rdata_idle: assert property (@(posedge clk)
        disable iff (!rst_s2_r)
        !rd |=> rdata == 32'h0000_0000)
        else $error("read data outside a read cycle");
    a_bad_addr: assert property (@(posedge clk)
        disable iff (!rst_s2_r)
        rd && (addr[1:0] != 2'h0 || addr >= 8'(4 * NUM_PADS)) |=>
            rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    c_write_read: cover property (@(posedge clk) disable iff (!rst_s2_r)
        wr ##[1:2] rd);
    c_fabric: cover property (@(posedge clk) disable iff (!rst_s2_r)
        st_r.word[9][4:3] == PCR_SRC_FABRIC);
    c_other: cover property (@(posedge clk) disable iff (!rst_s2_r)
        st_r.word[9][4:3] == PCR_SRC_OTHER);
    c_spare_src: cover property (@(posedge clk) disable iff (!rst_s2_r)
        st_r.word[9][4:3] == 2'h3);
    c_driver_on: cover property (@(posedge clk) disable iff (!rst_s2_r)
        !output_enable_n[9]);
endmodule

// *** testbench/test_pcr_bank.sv ***
// self-checking bench for the pad control register bank
module test_pcr_bank
    import pcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NP = PCR_NUM_PADS;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4*NP-1:0] func_out = '0;
    logic [NP-1:0] other_out = '0;
    logic [NP-1:0] other_oe_n = '1;
    logic [NP-1:0] fabric_out = '0;
    logic [NP-1:0] fabric_oe_n = '1;
    logic [31:0] rdata;
    logic [NP-1:0] pad_out, output_enable_n, slew_fast, rx_enable, schm;
    logic [2*NP-1:0] pad_pull, pad_drive;
    int fail_count = 0;
    int num_checks = 0;
    logic [31:0] d, w;
    logic [3:0] f;

    pcr_bank #(.NUM_PADS(NP)) dut (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .func_out(func_out),
        .other_out(other_out), .other_oe_n(other_oe_n),
        .fabric_out(fabric_out), .fabric_oe_n(fabric_oe_n), .rdata(rdata),
        .pad_out(pad_out), .output_enable_n(output_enable_n),
        .pad_pull(pad_pull), .pad_drive(pad_drive), .slew_fast(slew_fast),
        .rx_enable(rx_enable), .schmitt_input_enable(schm));

    always #10 clk = ~clk;

    // =====================================================
    // bus tasks and compare
    task automatic wr_at(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_at(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // =====================================================
    // tests
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        for (int p = 0; p < NP; p++) begin
            chk({31'h0, output_enable_n[p]}, 32'h1);
            chk({30'h0, pad_pull[2*p+:2]}, 32'h1);
            chk({30'h0, pad_drive[2*p+:2]}, 32'h1);
            chk({31'h0, slew_fast[p]}, 32'h0);
            chk({30'h0, rx_enable[p], schm[p]}, 32'h0);
            rd_at(8'(4*p), d);
            chk(d, 32'h0000_0160);
        end
        // write then read straight away, undefined bits must drop
        for (int p = 0; p < NP; p++) begin
            w = ~(32'(p) << 3);
            wr_at(8'(4*p), w);
            rd_at(8'(4*p), d);
            chk(d, w & 32'h0000_1FFB);
        end
        rd_at(8'h02, d);
        chk(d, 32'h0);
        rd_at(8'hB4, d);
        chk(d, 32'h0);
        for (int k = 0; k < 4; k++) begin
            w = 32'(k) << 6 | 32'(3 - k) << 8 | 32'(k % 2) << 10;
            w = w | 32'(k / 2) << 11 | 32'((k % 2) ^ (k / 2)) << 12;
            wr_at(8'h78, w);
            @(posedge clk);
            #1;
            chk({30'h0, pad_pull[60+:2]}, 32'(k));
            chk({30'h0, pad_drive[60+:2]}, 32'(3 - k));
            chk({31'h0, slew_fast[30]}, 32'(k % 2));
            chk({30'h0, schm[30], rx_enable[30]}, w[12:11]);
        end
        // pad 9 under every source code and function code
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 4; c++) begin
                f = (c / 2 == 1) ? 4'h5 : 4'hA;
                @(posedge clk);
                func_out[36+:4] <= f;
                other_out[9] <= c[0];
                other_oe_n[9] <= ~c[0];
                fabric_out[9] <= c[1];
                fabric_oe_n[9] <= c[0];
                wr_at(8'h24, 32'(c) | 32'(s) << 3 | 32'(c / 2) << 5);
                @(posedge clk);
                #1;
                d = (s == 1) ? {30'h0, c[0], ~c[0]} :
                    (s == 2) ? {30'h0, c[1], c[0]} :
                    {30'h0, f[c], c[1]};
                w = {30'h0, pad_out[9], output_enable_n[9]};
                chk(w, d);
            end
        end
        // a reset in mid-run must bring the word of pad 9 back to its reset value
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, output_enable_n[9]}, 32'h1);
        rd_at(8'h24, d);
        chk(d, 32'h0000_0160);
        @(posedge clk);
        #1;
        chk(rdata, 32'h0);
        conclude();
    end

    // the whole sequence needs well under 2000 cycles
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
endmodule
